/* design/spio_pad_mux.sv */
// Shared-port constants and the per-pad ownership multiplexers
package spio_pkg;
  localparam int unsigned REG_SEL_W = 2;
  localparam logic [1:0] SEL_DIRECTION = 2'h0;
  localparam logic [1:0] SEL_LATCH = 2'h1;
  localparam logic [1:0] SEL_PIN_STATE = 2'h2;
  localparam logic DIR_RST_BIT = 1'h1;
  localparam logic LATCH_RST_BIT = 1'h0;
  localparam logic SYNC_RST_BIT = 1'h0;
  localparam logic [31:0] READ_ZERO = 32'h0;
endpackage

module spio_pad_mux #(
  parameter int unsigned WIDTH = 16,
  parameter logic [WIDTH-1:0] IMPL_MASK = '1,
  parameter logic [WIDTH-1:0] INPUT_ONLY_MASK = '0
) (
  input wire logic [WIDTH-1:0] dir_bits, // Port direction, 1 = input
  input wire logic [WIDTH-1:0] latch_bits, // Port output latch
  input wire logic [WIDTH-1:0] periph_en, // Peripheral enabled per pin
  input wire logic [WIDTH-1:0] periph_oe, // Peripheral actively driving per pin
  input wire logic [WIDTH-1:0] periph_out, // Peripheral output data per pin
  output logic [WIDTH-1:0] periph_owns, // Peripheral owns the pad driver
  output logic [WIDTH-1:0] pad_out, // Pad output data
  output logic [WIDTH-1:0] pad_oe // Pad output enable, high drives
);
  // Input-only peripherals never compete for the driver, so those bits act as dedicated ports
  always_comb
  begin
    periph_owns = periph_en & periph_oe & ~INPUT_ONLY_MASK & IMPL_MASK;
    // Data and enable each pass through their own multiplexer
    pad_out = ((periph_owns & periph_out) | (~periph_owns & latch_bits)) & IMPL_MASK;
    pad_oe = (periph_owns | (~periph_owns & ~dir_bits)) & IMPL_MASK;
  end
endmodule // spio_pad_mux

/* design/spio_port.sv */
// Shared parallel I/O port: direction, latch and pin-state registers with pad sharing

module spio_port #(
  parameter int unsigned WIDTH = 16,
  parameter logic [WIDTH-1:0] IMPL_MASK = '1,
  parameter logic [WIDTH-1:0] INPUT_ONLY_MASK = '0
) (
  input wire logic core_clk, // Core clock, 100 MHz
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic [spio_pkg::REG_SEL_W-1:0] reg_sel, // Register select
  input wire logic reg_wr, // Write strobe, one cycle
  input wire logic [WIDTH-1:0] reg_wdata, // Write data
  output logic [WIDTH-1:0] reg_rdata, // Read data of selected register
  input wire logic [WIDTH-1:0] analog_sel, // Pin configured as analog input
  input wire logic [WIDTH-1:0] periph_en, // Peripheral enabled per pin
  input wire logic [WIDTH-1:0] periph_oe, // Peripheral actively driving per pin
  input wire logic [WIDTH-1:0] periph_out, // Peripheral output data per pin
  output logic [WIDTH-1:0] periph_in, // Synchronised pin levels for peripherals
  input wire logic [WIDTH-1:0] pad_in, // Pad input level
  output logic [WIDTH-1:0] pad_out, // Pad output data
  output logic [WIDTH-1:0] pad_oe // Pad output enable, high drives
);
  localparam logic [WIDTH-1:0] DIR_RST = {WIDTH{spio_pkg::DIR_RST_BIT}} & IMPL_MASK;
  localparam logic [WIDTH-1:0] LATCH_RST = {WIDTH{spio_pkg::LATCH_RST_BIT}};
  localparam logic [WIDTH-1:0] SYNC_RST = {WIDTH{spio_pkg::SYNC_RST_BIT}};

  logic [WIDTH-1:0] dir_ff;
  logic [WIDTH-1:0] latch_ff;
  logic [WIDTH-1:0] pin_meta_ff;
  logic [WIDTH-1:0] pin_sync_ff;
  logic [WIDTH-1:0] rdata_ff;
  logic [WIDTH-1:0] nxt_rdata;
  logic [WIDTH-1:0] periph_owns;

  function automatic logic [WIDTH-1:0] keep_impl(input logic [WIDTH-1:0] v);
    keep_impl = v & IMPL_MASK;
  endfunction

  // Two writable registers per pin; absent bits never store anything
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      dir_ff <= DIR_RST;
    else if (reg_wr && reg_sel == spio_pkg::SEL_DIRECTION)
      dir_ff <= keep_impl(reg_wdata);
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      latch_ff <= LATCH_RST;
    else if (reg_wr && (reg_sel == spio_pkg::SEL_LATCH || reg_sel == spio_pkg::SEL_PIN_STATE))
      latch_ff <= keep_impl(reg_wdata);
  end

  // The first stage feeds only the second
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      pin_meta_ff <= SYNC_RST;
      pin_sync_ff <= SYNC_RST;
    end
    else
    begin
      pin_meta_ff <= pad_in;
      pin_sync_ff <= pin_meta_ff;
    end
  end

  assign periph_in = pin_sync_ff;

  // Read data is registered, so a read sees state one cycle old; software spacing covers it
  always_comb
  begin
    if (reg_sel == spio_pkg::SEL_DIRECTION)
      nxt_rdata = dir_ff;
    else if (reg_sel == spio_pkg::SEL_LATCH)
      nxt_rdata = latch_ff;
    else if (reg_sel == spio_pkg::SEL_PIN_STATE)
      nxt_rdata = keep_impl(pin_sync_ff & ~analog_sel);
    else
      nxt_rdata = spio_pkg::READ_ZERO[WIDTH-1:0];
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      rdata_ff <= LATCH_RST;
    else
      rdata_ff <= nxt_rdata;
  end

  assign reg_rdata = rdata_ff;

  // Every pin goes through the sharing multiplexers
  spio_pad_mux #(
    .WIDTH(WIDTH),
    .IMPL_MASK(IMPL_MASK),
    .INPUT_ONLY_MASK(INPUT_ONLY_MASK)
  ) u_pad_mux (
    .dir_bits(dir_ff),
    .latch_bits(latch_ff),
    .periph_en(periph_en),
    .periph_oe(periph_oe),
    .periph_out(periph_out),
    .periph_owns(periph_owns),
    .pad_out(pad_out),
    .pad_oe(pad_oe)
  );

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  a_reset_all_inputs: assert property (
    !$past(rst_n) |-> (dir_ff == DIR_RST && (pad_oe & ~periph_owns) == '0))
    else $error("direction bits not all input after reset");

  a_input_driver_off: assert property (
    (dir_ff & ~periph_owns & pad_oe) == '0)
    else $error("port driver on for an input pin");

  a_latch_write_read: assert property (
    reg_wr && reg_sel == spio_pkg::SEL_LATCH ##1 reg_sel == spio_pkg::SEL_LATCH
    |=> reg_rdata == keep_impl($past(reg_wdata, 2)))
    else $error("latch write not read back");

  a_pin_write_latch: assert property (
    reg_wr && reg_sel == spio_pkg::SEL_PIN_STATE |=> latch_ff == keep_impl($past(reg_wdata)))
    else $error("pin-state write did not reach latch");

  a_pin_read_sync: assert property (
    $past(rst_n, 2) && $past(rst_n) && reg_sel == spio_pkg::SEL_PIN_STATE
    |=> reg_rdata == keep_impl($past(pad_in, 3) & ~$past(analog_sel)))
    else $error("pin-state read not the twice-synchronised level");

  a_periph_owns_pad: assert property (
    (periph_owns & ~(pad_oe & ~(pad_out ^ periph_out))) == '0)
    else $error("peripheral does not own its pad");

  a_port_owns_pad: assert property (
    ((~periph_owns & IMPL_MASK) & (pad_out ^ latch_ff | pad_oe ^ ~dir_ff)) == '0)
    else $error("idle peripheral pin not under port control");

  a_absent_bits_zero: assert property (
    ((dir_ff | latch_ff | pad_oe | reg_rdata) & ~IMPL_MASK) == '0)
    else $error("absent port bit not zero");

  a_dir_write_pad: assert property (
    reg_wr && reg_sel == spio_pkg::SEL_DIRECTION
    |=> ((~periph_owns & IMPL_MASK) & (pad_oe ^ ~$past(reg_wdata))) == '0)
    else $error("direction write did not steer the driver");

  a_dir_hold: assert property (
    !(reg_wr && reg_sel == spio_pkg::SEL_DIRECTION) |=> dir_ff == $past(dir_ff))
    else $error("direction bits changed without a write");

  a_latch_hold: assert property (
    !(reg_wr && (reg_sel == spio_pkg::SEL_LATCH || reg_sel == spio_pkg::SEL_PIN_STATE))
    |=> latch_ff == $past(latch_ff))
    else $error("latch changed without a write");

  a_latch_write: assert property (
    reg_wr && reg_sel == spio_pkg::SEL_LATCH |=> latch_ff == keep_impl($past(reg_wdata)))
    else $error("latch write not stored");

  a_port_write_pad: assert property (
    reg_wr && reg_sel == spio_pkg::SEL_LATCH
    |=> ((~periph_owns & ~dir_ff & IMPL_MASK) & (pad_out ^ $past(reg_wdata))) == '0)
    else $error("latch write did not reach output pins");

  a_pin_state_no_dir: assert property (
    reg_wr && reg_sel == spio_pkg::SEL_PIN_STATE |=> dir_ff == $past(dir_ff))
    else $error("pin-state write touched the direction bits");

  a_dir_read_back: assert property (
    reg_sel == spio_pkg::SEL_DIRECTION |=> reg_rdata == $past(dir_ff))
    else $error("direction read does not return the stored bits");

  a_unmapped_read_zero: assert property (
    reg_sel != spio_pkg::SEL_DIRECTION && reg_sel != spio_pkg::SEL_LATCH
    && reg_sel != spio_pkg::SEL_PIN_STATE |=> reg_rdata == '0)
    else $error("unmapped select read not zero");

  a_analog_reads_low: assert property (
    reg_sel == spio_pkg::SEL_PIN_STATE |=> (reg_rdata & $past(analog_sel)) == '0)
    else $error("analog pin did not read low");

  // Peripherals see the twice-sampled level that software reads, without its analog_sel masking, even while they drive
  a_periph_in_sync: assert property (
    $past(rst_n, 2) && $past(rst_n) |-> periph_in == $past(pad_in, 2))
    else $error("peripheral input not the twice-synchronised level");

  a_input_only_port: assert property (
    (periph_owns & INPUT_ONLY_MASK) == '0)
    else $error("input-only function took a pad driver");

  a_owner_needs_enable: assert property (
    (periph_owns & ~(periph_en & periph_oe)) == '0)
    else $error("pad owned by a peripheral that is not driving");

  a_enabled_idle_port: assert property (
    ((periph_en & ~periph_oe & IMPL_MASK) & (pad_oe ^ ~dir_ff | pad_out ^ latch_ff)) == '0)
    else $error("enabled idle peripheral blocked the port");

  a_absent_out_zero: assert property (
    (pad_out & ~IMPL_MASK) == '0)
    else $error("absent port bit drives data");
endmodule // spio_port

/* testbench/spio_pin_model.sv */
// Pin-side model: pads driven by the port win, otherwise the outside level
module spio_pin_model (
  input wire logic [15:0] pad_out, // Pad data from the port
  input wire logic [15:0] pad_oe, // Pad drive enable
  input wire logic [15:0] ext_level, // Level forced from outside
  output logic [15:0] pad_in // Resulting pin level
);
  timeunit 1ns;
  timeprecision 1ns;
  // No contention modelled: a driven pad always reads back its own data
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_level);
endmodule // spio_pin_model

/* testbench/tb.sv */
// Self-checking bench for the shared parallel port
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] IMPL = 16'h7fff;
  localparam logic [15:0] INPO = 16'h0001;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] reg_sel = 2'h0;
  logic reg_wr = 1'b0;
  logic [15:0] reg_wdata = 16'h0, analog_sel = 16'h0, ext_level = 16'h0;
  logic [15:0] periph_en = 16'h0, periph_oe = 16'h0, periph_out = 16'h0;
  logic [15:0] reg_rdata, periph_in, pad_in, pad_out, pad_oe;
  int err_count = 0;
  int num_checks = 0;
  always #5 core_clk = ~core_clk;
  spio_port #(.WIDTH(16), .IMPL_MASK(IMPL), .INPUT_ONLY_MASK(INPO)) i_spio_port (
    .core_clk(core_clk), .rst_n(rst_n), .reg_sel(reg_sel), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .analog_sel(analog_sel),
    .periph_en(periph_en), .periph_oe(periph_oe), .periph_out(periph_out),
    .periph_in(periph_in), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe));
  spio_pin_model i_spio_pin_model (.pad_out(pad_out), .pad_oe(pad_oe),
    .ext_level(ext_level), .pad_in(pad_in));
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp)
    begin
      $display("Error %s expected %h seen %h", nm, exp, got);
      err_count++;
    end
  endtask
  task automatic wr(input logic [1:0] s, input logic [15:0] d);
    @(posedge core_clk);
    reg_sel <= s;
    reg_wr <= 1'b1;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  // Extra edge keeps the software spacing between a port change and its read
  task automatic rd(input logic [1:0] s, input logic [15:0] exp, input string nm);
    @(posedge core_clk);
    reg_sel <= s;
    repeat (3) @(posedge core_clk);
    #1 chk(nm, exp, reg_rdata);
  endtask
  task automatic t_reset();
    rd(2'h0, IMPL, "dir");
    chk("oe", 16'h0, pad_oe);
    rd(2'h1, 16'h0, "latch");
    $display("reset test done");
  endtask
  task automatic t_regs();
    wr(2'h1, 16'hffff);
    rd(2'h1, IMPL, "latch");
    wr(2'h0, 16'h00f0);
    chk("oe", 16'h7f0f, pad_oe);
    chk("out", 16'h7f0f, pad_out & pad_oe);
    wr(2'h2, 16'h1234);
    rd(2'h1, 16'h1234, "latch");
    wr(2'h3, 16'habcd);
    rd(2'h3, 16'h0, "unmapped");
    rd(2'h1, 16'h1234, "latch");
    $display("register test done");
  endtask
  task automatic t_pins();
    wr(2'h0, 16'hffff);
    @(posedge core_clk);
    ext_level <= 16'ha5c3;
    analog_sel <= 16'h0f00;
    rd(2'h2, 16'h25c3 & 16'hf0ff, "pin");
    wr(2'h0, 16'h0000);
    wr(2'h1, 16'h00ff);
    rd(2'h2, 16'h00ff, "pin");
    $display("pin test done");
  endtask
  task automatic t_periph();
    wr(2'h0, 16'h0006);
    @(posedge core_clk);
    periph_en <= 16'h0007;
    periph_oe <= 16'h0005;
    periph_out <= 16'h0f0f;
    @(posedge core_clk);
    #1 chk("oe", 16'h7ffd, pad_oe);
    chk("out", 16'h00fd, pad_out & pad_oe);
    rd(2'h2, 16'h00ff, "pin");
    chk("periph_in", 16'h00ff, periph_in & IMPL);
    $display("peripheral test done");
  endtask
  // Reset again in mid-run with a peripheral still driving bit 2
  task automatic t_mid_reset();
    wr(2'h0, 16'h0000);
    chk("oe", 16'h7fff, pad_oe);
    wr(2'h1, 16'h5555);
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    #1 chk("oe", 16'h0004, pad_oe);
    chk("out", 16'h0004, pad_out & pad_oe);
    rd(2'h0, IMPL, "dir");
    rd(2'h1, 16'h0, "latch");
    $display("second reset test done");
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    t_reset();
    t_regs();
    t_pins();
    t_periph();
    t_mid_reset();
    give_verdict();
  end
  initial
  begin
    #20000;
    err_count++;
    give_verdict();
  end
endmodule // tb
